// >>> cfg_status_monitor.sv
// Concurrent checks on the ports of the configuration status block.
// Assumes it is bound into config_status_indicator with the same counts.
`timescale 1ns/100ps
module cfg_status_monitor import cfg_status_pkg::*; #(
   parameter int unsigned IMG_BYTES_P = 16,
   parameter int unsigned FAST_HALF_CYC_P = 4
) (
   input wire logic clk_i, // Clock.
   input wire logic rst_i, // Reset.
   input wire logic wb_cyc_i, // Bus cycle.
   input wire logic wb_stb_i, // Bus strobe.
   input wire logic wb_ack_o, // Bus ack.
   input wire cfg_status_pkg::flash_bus_t flash_o, // Flash pins.
   input wire logic [7:0] flash_data_i, // Flash byte.
   input wire cfg_status_pkg::tgt_ctrl_t tgt_o, // Target pins.
   input wire logic tgt_conf_done_i, // Target done.
   input wire logic factory_select_button_i, // Factory button.
   input wire logic reset_and_configure_button_i, // Reset button.
   input wire cfg_status_pkg::lamps_t lamps_o // Lamps.
);
   int still;
   logic load_q;

   default clocking mon_cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // Slack of three cycles covers lamp lag and blink phase at stream start.
   always_ff @(posedge clk_i) begin
      load_q <= lamps_o.loading_lamp;
      if (rst_i || flash_o.ce_n || load_q != lamps_o.loading_lamp) begin
         still <= 0;
      end else begin
         still <= still + 1;
      end
   end

   AST_ACK_ONE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   AST_ACK_DROP: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   AST_CFG_PULSE: assert property ($fell(tgt_o.config_n) |->
      ##124 !tgt_o.config_n ##1 tgt_o.config_n) else $error("config pulse length");
   AST_FACT_SKIP: assert property ($rose(factory_select_button_i) |->
      ##[1:3] !tgt_o.config_n && !tgt_o.as_mode) else $error("factory start");
   AST_FULL_SEQ: assert property ($rose(reset_and_configure_button_i) |->
      ##[1:3] !tgt_o.config_n && tgt_o.as_mode) else $error("serial first");
   AST_BASE: assert property ($fell(flash_o.ce_n) |->
      flash_o.addr == USER_BASE || flash_o.addr == FACT_BASE) else $error("image base");
   AST_STEP: assert property (!flash_o.ce_n && !$past(flash_o.ce_n) |->
      flash_o.addr == $past(flash_o.addr) + 24'h1) else $error("address step");
   AST_LAST: assert property ($rose(flash_o.ce_n) |->
      $past(flash_o.addr[19:0]) == 20'(IMG_BYTES_P - 1)) else $error("image length");
   AST_DATA: assert property (!flash_o.ce_n |->
      ##2 tgt_o.data_valid && tgt_o.data == $past(flash_data_i)) else $error("byte lost");
   AST_USER_LAMP: assert property ($fell(flash_o.ce_n) &&
      flash_o.addr == USER_BASE |-> ##[0:2] lamps_o.user_image_lamp) else $error("user lamp");
   AST_LOAD_OFF: assert property (flash_o.ce_n [*4] |-> !lamps_o.loading_lamp)
      else $error("loading lamp idle");
   AST_LOAD_BLINK: assert property (still <= FAST_HALF_CYC_P + 3)
      else $error("loading lamp not blinking");
   AST_FLASH_LAMP: assert property ($stable(flash_o.ce_n) |->
      lamps_o.flash_activity_lamp == !flash_o.ce_n) else $error("flash lamp");
   AST_DONE_LAMP: assert property (!$past(rst_i) |->
      lamps_o.done_lamp == $past(tgt_conf_done_i)) else $error("done lamp");

   cover property ($fell(flash_o.ce_n) && flash_o.addr == USER_BASE);
   cover property ($rose(lamps_o.error_lamp));
   cover property ($rose(factory_select_button_i));
endmodule // cfg_status_monitor

bind config_status_indicator cfg_status_monitor #(.IMG_BYTES_P(IMG_BYTES_P),
   .FAST_HALF_CYC_P(FAST_HALF_CYC_P)) i_monitor (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
   .wb_ack_o, .flash_o, .flash_data_i, .tgt_o, .tgt_conf_done_i, .factory_select_button_i,
   .reset_and_configure_button_i, .lamps_o);

// >>> cfg_status_pkg.sv
// Shared constants, types and register map of the configuration status block.
// Assumes a 250 MHz controller clock and byte-wide flash with one cycle of read latency.
package cfg_status_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 250_000_000;
   localparam int CLK_NS = 4;
   localparam int CYC_PER_MS = CLK_HZ / 1000;
   localparam int CFG_PULSE_NS = 500;
   localparam int CFG_PULSE_CYC = (CFG_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int FAST_HALF_MS = 125;
   localparam int SLOW_HALF_MS = 500;
   localparam int FAST_HALF_CYC = FAST_HALF_MS * CYC_PER_MS;
   localparam int SLOW_HALF_CYC = SLOW_HALF_MS * CYC_PER_MS;
   localparam int AS_WAIT_MS = 200;
   localparam int DONE_WAIT_MS = 10;
   localparam int AS_WAIT_CYC = AS_WAIT_MS * CYC_PER_MS;
   localparam int DONE_WAIT_CYC = DONE_WAIT_MS * CYC_PER_MS;

   // ----------------------------------------------------------------
   // Flash layout
   // ----------------------------------------------------------------
   localparam int FADDR_W = 24;
   localparam logic [23:0] USER_BASE = 24'hC00000;
   localparam logic [23:0] FACT_BASE = 24'hE00000;
   localparam int IMG_BYTES = 32'h0010_0000;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
   localparam logic [7:0] REG_IRQ_CLEAR = 8'h0C;
   localparam logic [7:0] REG_IRQ_ENABLE = 8'h10;
   localparam int CTRL_START = 0;
   localparam int CTRL_FORCE_FACT = 1;
   localparam int ST_BUSY = 0;
   localparam int ST_LOADED = 1;
   localparam int ST_FAILED = 2;
   localparam int ST_SRC_LSB = 3;
   localparam int ST_LAMP_LSB = 8;
   localparam int EV_W = 5;
   localparam int EV_LOAD_SERIAL = 0;
   localparam int EV_LOAD_USER = 1;
   localparam int EV_LOAD_FACT = 2;
   localparam int EV_ERROR = 3;
   localparam int EV_FALLBACK = 4;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {SRC_SERIAL, SRC_USER, SRC_FACT} src_t;

   typedef struct packed {
      logic ce_n;
      logic [FADDR_W-1:0] addr;
   } flash_bus_t;

   typedef struct packed {
      logic config_n;
      logic as_mode;
      logic data_valid;
      logic [7:0] data;
   } tgt_ctrl_t;

   typedef struct packed {
      logic loading_lamp;
      logic error_lamp;
      logic user_image_lamp;
      logic factory_image_lamp;
      logic done_lamp;
      logic flash_activity_lamp;
   } lamps_t;

endpackage

// >>> cfg_target_model.sv
// Behavioural target device and byte-wide flash facing the configuration block.
// Assumes flash and target pins are driven from clk_i by the block.
`timescale 1ns/100ps
module cfg_target_model import cfg_status_pkg::*; #(
   parameter int unsigned IMG_BYTES_P = 16
) (
   input wire logic clk_i, // Clock.
   input wire logic rst_i, // Reset.
   input wire cfg_status_pkg::flash_bus_t flash_i, // Flash select, address.
   input wire cfg_status_pkg::tgt_ctrl_t tgt_i, // Target pins.
   input wire logic serial_ok_i, // Serial image good.
   input wire logic user_ok_i, // User image good.
   input wire logic fact_ok_i, // Factory image good.
   output logic [7:0] flash_data_o, // Flash byte.
   output logic conf_done_o, // Configured.
   output logic status_n_o // Error, low active.
);
   int cnt;
   logic fact;

   // A deselected flash shows a changing byte so stale data is never mistaken for valid.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flash_data_o <= 8'h5A;
      end else if (!flash_i.ce_n) begin
         flash_data_o <= flash_i.addr[7:0] ^ flash_i.addr[23:16];
      end else begin
         flash_data_o <= ~flash_data_o;
      end
      if (!flash_i.ce_n) begin
         fact <= flash_i.addr[21];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || !tgt_i.config_n) begin
         cnt <= 0;
         conf_done_o <= 1'b0;
         status_n_o <= 1'b1;
      end else if (tgt_i.as_mode) begin
         cnt <= cnt + 1;
         if (cnt == 10 && serial_ok_i) conf_done_o <= 1'b1;
      end else if (tgt_i.data_valid) begin
         cnt <= cnt + 1;
         if (cnt == IMG_BYTES_P - 1) begin
            conf_done_o <= fact ? fact_ok_i : user_ok_i;
            status_n_o <= fact ? fact_ok_i : user_ok_i;
         end
      end
   end
endmodule // cfg_target_model

// >>> config_status_indicator.sv
// Configuration sequencer of the board controller with its status lamps.
// Assumes all inputs synchronous to clk_i, flash data valid one cycle after address,
// and a target that raises conf_done when loaded and pulls status_n low on error.
// Function
// - Blink the loading lamp while bytes stream from flash into the target.
// - Light the error lamp when no flash image could be loaded.
// - User lamp on from user transfer start, kept on after success.
// - After a serial-memory load the user lamp blinks slowly.
// - Factory lamp on from factory transfer start, kept on after success.
// - Done lamp follows the target configuration-complete signal.
// - Flash activity lamp lights while flash chip enable is low.
// - Handle reset conditions and load target from flash or serial memory.
// - Try serial memory, then user image, then factory image; stop on success.
// - Factory button skips serial memory and user image.
// - Start on power-on, reset button, factory button or reconfig request.
// - User image at 0x00C00000, factory at 0x00E00000, 1 MB each.
`timescale 1ns/100ps
module config_status_indicator #(
   parameter int unsigned IMG_BYTES_P = cfg_status_pkg::IMG_BYTES,
   parameter int unsigned AS_WAIT_CYC_P = cfg_status_pkg::AS_WAIT_CYC,
   parameter int unsigned DONE_WAIT_CYC_P = cfg_status_pkg::DONE_WAIT_CYC,
   parameter int unsigned FAST_HALF_CYC_P = cfg_status_pkg::FAST_HALF_CYC,
   parameter int unsigned SLOW_HALF_CYC_P = cfg_status_pkg::SLOW_HALF_CYC
) (
   input wire logic clk_i, // Controller clock.
   input wire logic rst_i, // Synchronous reset, power-on.
   input wire logic ce_i, // Clock enable, freezes all state.
   input wire logic wb_cyc_i, // Wishbone cycle.
   input wire logic wb_stb_i, // Wishbone strobe.
   input wire logic wb_we_i, // Wishbone write enable.
   input wire logic [7:0] wb_adr_i, // Wishbone byte address.
   input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
   input wire logic [31:0] wb_dat_i, // Wishbone write data.
   output logic [31:0] wb_dat_o, // Wishbone read data.
   output logic wb_ack_o, // Wishbone acknowledge.
   output cfg_status_pkg::flash_bus_t flash_o, // Flash chip enable and address.
   input wire logic [7:0] flash_data_i, // Flash read data.
   output cfg_status_pkg::tgt_ctrl_t tgt_o, // Target configuration pins.
   input wire logic tgt_status_n_i, // Target error, low active.
   input wire logic tgt_conf_done_i, // Target configuration complete.
   input wire logic tgt_reconfig_req_n_i, // Target reconfig request, low active.
   input wire logic factory_select_button_i, // Factory button pressed, high.
   input wire logic reset_and_configure_button_i, // Reset button pressed, high.
   output cfg_status_pkg::lamps_t lamps_o, // Status lamps, high is lit.
   output logic irq_o // Level interrupt.
);
   import cfg_status_pkg::*;

   typedef enum logic [2:0] {
      S_IDLE, S_PULSE, S_AS_WAIT, S_STREAM, S_DONE_WAIT, S_LOADED, S_FAILED
   } state_t;

   state_t state;
   src_t src;
   logic [31:0] cnt;
   logic start_pend;
   logic factory_pend;
   logic fact_btn_q;
   logic rst_btn_q;
   logic reconf_q;
   logic rd_pend;
   logic force_fact;
   logic sw_start;
   logic [EV_W-1:0] ev;
   logic [EV_W-1:0] irq_status;
   logic [EV_W-1:0] irq_enable;
   logic [31:0] fast_cnt;
   logic [31:0] slow_cnt;
   logic fast_blink;
   logic slow_blink;
   logic start_now;
   logic fact_now;
   logic wb_req;
   logic wb_wr;
   logic fact_only;

   function automatic logic [FADDR_W-1:0] src_base(input src_t s);
      return (s == SRC_FACT) ? FACT_BASE : USER_BASE;
   endfunction

   function automatic logic at_limit(input logic [31:0] c, input int unsigned lim);
      return c >= 32'(lim - 1);
   endfunction

   // ----------------------------------------------------------------
   // Start sources
   // ----------------------------------------------------------------
   // Buttons and the request line are level inputs; only their
   // leading edge starts a sequence so a held button does not loop.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fact_btn_q <= 1'b0;
         rst_btn_q <= 1'b0;
         reconf_q <= 1'b1;
      end else if (ce_i) begin
         fact_btn_q <= factory_select_button_i;
         rst_btn_q <= reset_and_configure_button_i;
         reconf_q <= tgt_reconfig_req_n_i;
      end
   end

   assign fact_now = factory_select_button_i & ~fact_btn_q;
   // A held force bit steers software starts only; power-on, the reset button and requests keep the order.
   assign fact_only = fact_now | (sw_start & force_fact);
   assign start_now = start_pend | fact_now | sw_start |
      (reset_and_configure_button_i & ~rst_btn_q) | (~tgt_reconfig_req_n_i & reconf_q);

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= S_IDLE;
         src <= SRC_SERIAL;
         cnt <= 32'h0;
         start_pend <= 1'b1; // Power-on starts a load.
         factory_pend <= 1'b0;
         flash_o <= '{ce_n: 1'b1, addr: '0};
         tgt_o.config_n <= 1'b1;
         tgt_o.as_mode <= 1'b0;
         ev <= '0;
         rd_pend <= 1'b0;
         tgt_o.data_valid <= 1'b0;
         tgt_o.data <= 8'h00;
      end else if (ce_i) begin
         ev <= '0;
         start_pend <= 1'b0;
         // Each flash byte is captured one cycle after its address and
         // presented to the target with a one-cycle valid strobe.
         rd_pend <= ~flash_o.ce_n & ~start_now;
         tgt_o.data_valid <= rd_pend;
         if (rd_pend) begin
            tgt_o.data <= flash_data_i;
         end
         if (start_now) begin
            // A new start aborts any sequence in progress.
            factory_pend <= fact_only;
            state <= S_PULSE;
            src <= fact_only ? SRC_FACT : SRC_SERIAL;
            cnt <= 32'h0;
            flash_o.ce_n <= 1'b1;
            tgt_o.config_n <= 1'b0;
            tgt_o.as_mode <= ~fact_only;
         end else begin
            unique case (state)
               S_IDLE, S_LOADED, S_FAILED: begin
               end
               S_PULSE: begin
                  cnt <= cnt + 32'h1;
                  if (at_limit(cnt, CFG_PULSE_CYC)) begin
                     tgt_o.config_n <= 1'b1;
                     cnt <= 32'h0;
                     if (src == SRC_SERIAL) begin
                        state <= S_AS_WAIT;
                     end else begin
                        state <= S_STREAM;
                        flash_o.ce_n <= 1'b0;
                        flash_o.addr <= src_base(src);
                     end
                  end
               end
               S_AS_WAIT: begin
                  cnt <= cnt + 32'h1;
                  if (tgt_conf_done_i) begin
                     state <= S_LOADED;
                     ev[EV_LOAD_SERIAL] <= 1'b1;
                  end else if (!tgt_status_n_i || at_limit(cnt, AS_WAIT_CYC_P)) begin
                     // Serial memory failed: fall through to the user image.
                     state <= S_PULSE;
                     src <= SRC_USER;
                     cnt <= 32'h0;
                     tgt_o.config_n <= 1'b0;
                     tgt_o.as_mode <= 1'b0;
                     ev[EV_FALLBACK] <= 1'b1;
                  end
               end
               S_STREAM: begin
                  cnt <= cnt + 32'h1;
                  flash_o.addr <= flash_o.addr + 24'h1;
                  if (at_limit(cnt, IMG_BYTES_P)) begin
                     state <= S_DONE_WAIT;
                     flash_o.ce_n <= 1'b1;
                     cnt <= 32'h0;
                  end
               end
               S_DONE_WAIT: begin
                  cnt <= cnt + 32'h1;
                  if (tgt_conf_done_i && !rd_pend) begin
                     state <= S_LOADED;
                     ev[EV_LOAD_USER] <= (src == SRC_USER);
                     ev[EV_LOAD_FACT] <= (src == SRC_FACT);
                  end else if (!tgt_status_n_i || at_limit(cnt, DONE_WAIT_CYC_P)) begin
                     cnt <= 32'h0;
                     if (src == SRC_USER) begin
                        state <= S_PULSE;
                        src <= SRC_FACT;
                        tgt_o.config_n <= 1'b0;
                        ev[EV_FALLBACK] <= 1'b1;
                     end else begin
                        state <= S_FAILED;
                        ev[EV_ERROR] <= 1'b1;
                     end
                  end
               end
               default: state <= S_IDLE;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Flash to target byte path
   // ----------------------------------------------------------------
   // The byte strobe and data live in the sequencer process: the target pins are one
   // struct, and a second process writing other fields of it would be a second driver.

   // ----------------------------------------------------------------
   // Blink dividers
   // ----------------------------------------------------------------
   // Free running so that all blinking lamps stay in phase.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fast_cnt <= 32'h0;
         fast_blink <= 1'b0;
      end else if (ce_i) begin
         fast_cnt <= fast_cnt + 32'h1;
         if (at_limit(fast_cnt, FAST_HALF_CYC_P)) begin
            fast_cnt <= 32'h0;
            fast_blink <= ~fast_blink;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         slow_cnt <= 32'h0;
         slow_blink <= 1'b0;
      end else if (ce_i) begin
         slow_cnt <= slow_cnt + 32'h1;
         if (at_limit(slow_cnt, SLOW_HALF_CYC_P)) begin
            slow_cnt <= 32'h0;
            slow_blink <= ~slow_blink;
         end
      end
   end

   // ----------------------------------------------------------------
   // Lamps
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lamps_o <= '0;
      end else if (ce_i) begin
         lamps_o.loading_lamp <= (state == S_STREAM) & fast_blink;
         lamps_o.error_lamp <= (state == S_FAILED);
         lamps_o.user_image_lamp <= ((src == SRC_USER) &&
            (state == S_STREAM || state == S_DONE_WAIT || state == S_LOADED)) ||
            ((src == SRC_SERIAL) && (state == S_LOADED) && slow_blink);
         lamps_o.factory_image_lamp <= (src == SRC_FACT) &&
            (state == S_STREAM || state == S_DONE_WAIT || state == S_LOADED);
         lamps_o.done_lamp <= tgt_conf_done_i;
         lamps_o.flash_activity_lamp <= ~flash_o.ce_n;
      end
   end

   // ----------------------------------------------------------------
   // Register bus
   // ----------------------------------------------------------------
   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wb_wr = wb_req & wb_we_i & wb_sel_i[0];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else if (ce_i) begin
         wb_ack_o <= wb_req;
         wb_dat_o <= 32'h0;
         if (wb_req && !wb_we_i) begin
            unique case (wb_adr_i)
               REG_CTRL: wb_dat_o[CTRL_FORCE_FACT] <= force_fact;
               REG_STATUS: begin
                  wb_dat_o[ST_BUSY] <= (state != S_IDLE) &&
                     (state != S_LOADED) && (state != S_FAILED);
                  wb_dat_o[ST_LOADED] <= (state == S_LOADED);
                  wb_dat_o[ST_FAILED] <= (state == S_FAILED);
                  wb_dat_o[ST_SRC_LSB +: 2] <= src;
                  wb_dat_o[ST_LAMP_LSB +: $bits(lamps_t)] <= lamps_o;
               end
               REG_IRQ_STATUS: wb_dat_o[EV_W-1:0] <= irq_status;
               REG_IRQ_ENABLE: wb_dat_o[EV_W-1:0] <= irq_enable;
               default: wb_dat_o <= 32'h0;
            endcase
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         force_fact <= 1'b0;
         sw_start <= 1'b0;
         irq_enable <= '0;
      end else if (ce_i) begin
         sw_start <= 1'b0;
         if (wb_wr && wb_adr_i == REG_CTRL) begin
            sw_start <= wb_dat_i[CTRL_START];
            force_fact <= wb_dat_i[CTRL_FORCE_FACT];
         end
         if (wb_wr && wb_adr_i == REG_IRQ_ENABLE) begin
            irq_enable <= wb_dat_i[EV_W-1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------
   // A new event in the cycle of a clear keeps its bit set.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_status <= '0;
      end else if (ce_i) begin
         if (wb_wr && wb_adr_i == REG_IRQ_CLEAR) begin
            irq_status <= (irq_status & ~wb_dat_i[EV_W-1:0]) | ev;
         end else begin
            irq_status <= irq_status | ev;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else if (ce_i) begin
         irq_o <= |(irq_status & irq_enable);
      end
   end

endmodule // config_status_indicator

// >>> config_status_indicator_tb_top.sv
// Self-checking bench of the configuration status block, its target and flash model.
// Assumes shortened counts at the instance; sequences never overlap.
`timescale 1ns/100ps
module config_status_indicator_tb_top;
   import cfg_status_pkg::*;
   logic clk, rst, cyc, stb, we, ack, st_n, done, req_n, fbtn, rbtn, irq, s_ok, u_ok, f_ok;
   logic [7:0] adr, fdat;
   logic [3:0] sel, wsel;
   logic ce;
   logic [31:0] wdat, rdat, q, seed, en;
   flash_bus_t flash;
   tgt_ctrl_t tgt;
   lamps_t lamps;
   int num_errors, check_count;

   config_status_indicator #(.IMG_BYTES_P(16), .AS_WAIT_CYC_P(50), .DONE_WAIT_CYC_P(50),
      .FAST_HALF_CYC_P(4), .SLOW_HALF_CYC_P(16)) i_dut (.clk_i(clk), .rst_i(rst),
      .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .flash_o(flash),
      .flash_data_i(fdat), .tgt_o(tgt), .tgt_status_n_i(st_n), .tgt_conf_done_i(done),
      .tgt_reconfig_req_n_i(req_n), .factory_select_button_i(fbtn),
      .reset_and_configure_button_i(rbtn), .lamps_o(lamps), .irq_o(irq));
   cfg_target_model i_model (.clk_i(clk), .rst_i(rst), .flash_i(flash),
      .tgt_i(tgt), .serial_ok_i(s_ok), .user_ok_i(u_ok), .fact_ok_i(f_ok),
      .flash_data_o(fdat), .conf_done_o(done), .status_n_o(st_n));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   function automatic logic [4:0] exp_ev(input logic fo, input logic s, u, f);
      logic [4:0] e;
      e = '0;
      if (!fo && s) e[EV_LOAD_SERIAL] = 1'b1;
      else if (!fo && u) e[EV_LOAD_USER] = 1'b1;
      else if (f) e[EV_LOAD_FACT] = 1'b1;
      else e[EV_ERROR] = 1'b1;
      e[EV_FALLBACK] = !fo && !s;
      return e;
   endfunction

   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_lamp(input logic got, input logic exp);
      chk_val({31'h0, got}, {31'h0, exp});
   endtask

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, wsel};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      {cyc, stb} <= 2'b00;
      @(posedge clk);
      if (n >= 20) begin
         num_errors++;
         finish_test();
      end
   endtask

   task automatic run_seq();
      int n;
      logic seen;
      seen = 1'b0;
      n = 0;
      do begin
         wb(1'b0, REG_STATUS, 32'h0);
         if (q[ST_BUSY] === 1'b1) seen = 1'b1;
         n++;
      end while (!(seen && q[ST_BUSY] === 1'b0) && n < 400);
      if (n >= 400) begin
         num_errors++;
         finish_test();
      end
   endtask

   // Kind: 0 reset button, 1 reconfig request, 2 factory button, 3 forced soft start, 4 none.
   task automatic scenario(input int kind, input logic s, u, f);
      logic [4:0] e;
      logic b;
      int tg;
      seed = xs(seed);
      en = seed;
      {s_ok, u_ok, f_ok} <= {s, u, f};
      e = exp_ev(kind == 2 || kind == 3, s, u, f);
      wb(1'b1, REG_IRQ_ENABLE, en);
      wb(1'b1, REG_IRQ_CLEAR, 32'h1F);
      if (kind == 0) rbtn <= 1'b1;
      if (kind == 1) req_n <= 1'b0;
      if (kind == 2) fbtn <= 1'b1;
      if (kind == 3) wb(1'b1, REG_CTRL, 32'h3);
      run_seq();
      {rbtn, req_n, fbtn} <= 3'b010;
      @(negedge clk);
      chk_lamp(lamps.error_lamp, e[EV_ERROR]);
      chk_lamp(lamps.done_lamp, !e[EV_ERROR]);
      chk_lamp(lamps.loading_lamp, 1'b0);
      chk_lamp(lamps.flash_activity_lamp, 1'b0);
      if (!e[EV_ERROR]) chk_lamp(lamps.factory_image_lamp, e[EV_LOAD_FACT]);
      tg = 0;
      repeat (64) begin
         b = lamps.user_image_lamp;
         @(negedge clk);
         if (b !== lamps.user_image_lamp) tg++;
      end
      if (e[EV_LOAD_SERIAL]) chk_lamp(tg inside {3, 4}, 1'b1);
      if (e[EV_LOAD_USER]) chk_val({lamps.user_image_lamp, tg[3:0]}, 5'h10);
      if (e[EV_LOAD_SERIAL]) begin
         // With the clock enable low the slow blink must stand still.
         @(posedge clk);
         ce <= 1'b0;
         @(negedge clk);
         b = lamps.user_image_lamp;
         tg = 0;
         repeat (40) begin
            @(negedge clk);
            if (b !== lamps.user_image_lamp) tg++;
         end
         @(posedge clk);
         ce <= 1'b1;
         chk_val(tg, 32'h0);
      end
      @(posedge clk);
      wb(1'b0, REG_IRQ_STATUS, 32'h0);
      chk_val(q & 32'h1F, {27'h0, e});
      chk_lamp(irq, |(e & en[4:0]));
      wb(1'b0, REG_STATUS, 32'h0);
      chk_val(q[2:0], {e[EV_ERROR], !e[EV_ERROR], 1'b0});
      if (!e[EV_ERROR]) chk_val(q[4:3], e[0] ? 2'd0 : (e[1] ? 2'd1 : 2'd2));
      wb(1'b0, REG_IRQ_ENABLE, 32'h0);
      chk_val(q[4:0], en[4:0]);
      wb(1'b1, REG_IRQ_CLEAR, 32'h1F);
      wb(1'b0, REG_IRQ_STATUS, 32'h0);
      chk_val(q & 32'h1F, 32'h0);
      chk_lamp(irq, 1'b0);
   endtask

   initial begin
      {rst, cyc, stb, we, adr, sel, wdat, fbtn, rbtn, req_n} = {1'b1, 49'h0, 1'b1};
      ce = 1'b1;
      wsel = 4'hF;
      {s_ok, u_ok, f_ok} = 3'b111;
      seed = 32'h20;
      num_errors = 0;
      check_count = 0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      scenario(4, 1'b1, 1'b1, 1'b1);
      wb(1'b1, 8'hFC, 32'hFFFF_FFFF);
      wb(1'b0, 8'hFC, 32'h0);
      chk_val(q, 32'h0);
      // A write with the low byte select off must leave the enables alone.
      wsel = 4'hE;
      wb(1'b1, REG_IRQ_ENABLE, ~en);
      wsel = 4'hF;
      wb(1'b0, REG_IRQ_ENABLE, 32'h0);
      chk_val(q[4:0], en[4:0]);
      scenario(0, 1'b0, 1'b1, 1'b1);
      scenario(1, 1'b0, 1'b0, 1'b1);
      scenario(2, 1'b1, 1'b1, 1'b0);
      scenario(3, 1'b1, 1'b1, 1'b1);
      scenario(0, 1'b0, 1'b0, 1'b0);
      repeat (6) begin
         seed = xs(seed);
         scenario(int'(seed[1:0]), seed[2], seed[3], seed[4]);
      end
      finish_test();
   end
endmodule // config_status_indicator_tb_top
